// ===== logic/dgs_pkg.sv
package dgs_pkg;
  // Memory geometry
  localparam int ADDR_W = 6;
  localparam int WORD_W = 6;
  localparam int PAIR_W = 12;
  localparam int CFG_DEPTH = 32;
  localparam int NUM_MOTORS = 3;
  // Word fields
  localparam int NXM_BIT = 5;
  localparam int CODE_W = 5;
  // Register port: bit 6 of the address is the memory-or-register select
  localparam int BUS_ADDR_W = 7;
  localparam int SEL_BIT = 6;
  localparam int HALF_BIT = 5;
  // Own control registers (select bit 0)
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_STATUS = 6'h01;
  localparam logic [5:0] REG_PHASE = 6'h02;
  localparam int CTRL_LAST_LSB = 0;
  localparam int CTRL_GO_BIT = 2;
  localparam logic [1:0] LAST_RESET = 2'h0;
  // Signal codes
  localparam logic [4:0] CODE_COIL_A = 5'h00;
  localparam logic [4:0] CODE_COIL_B = 5'h08;
  localparam logic [4:0] CODE_ZERO = 5'h10;
  localparam logic [4:0] CODE_ONE = 5'h11;
  localparam logic [4:0] CODE_DIR = 5'h12;
  localparam logic [4:0] CODE_STEP = 5'h13;
  // Link timing: half period of the driver serial clock in system clocks
  localparam int LINK_HALF = 16;
endpackage : dgs_pkg

// ===== logic/wave_expander.sv
`timescale 1ns/1ps
// Turns a 7-bit phase into coil A/B amplitude, polarity, decay from a quarter table
module wave_expander (
  input wire logic [6:0] phase,
  input wire logic [5:0] table_word,
  input wire logic [5:0] table_word_b,
  output logic [4:0] table_index,
  output logic [4:0] table_index_b,
  output logic [7:0] coil_a_bits,
  output logic [7:0] coil_b_bits
);
  logic [6:0] phase_b;
  logic [5:0] amp_a;
  logic [5:0] amp_b;

  function automatic logic [4:0] quarter_index(input logic [6:0] ph);
    // Mirror odd quarters so the table is read backward there
    quarter_index = ph[5] ? 5'(5'h1f - ph[4:0]) : ph[4:0];
  endfunction : quarter_index

  // Coil B runs a quarter period ahead of coil A [RULE13]
  assign phase_b = 7'(phase + 7'h20);
  // Each coil looks up its own entry, so coil B traces the shifted wave, not a copy of A [RULE13]
  assign table_index = quarter_index(phase);
  assign table_index_b = quarter_index(phase_b);
  assign amp_a = table_word;
  assign amp_b = table_word_b;
  // Polarity follows the half period; fast decay on the falling quarters [RULE13]
  assign coil_a_bits = {phase[5], phase[6], amp_a};
  assign coil_b_bits = {phase_b[5], phase_b[6], amp_b};
endmodule : wave_expander

// ===== logic/code_select.sv
`timescale 1ns/1ps
// Picks one snapshot bit by signal code
module code_select (
  input wire logic [4:0] code,
  input wire logic [7:0] coil_a,
  input wire logic [7:0] coil_b,
  input wire logic dir,
  input wire logic step,
  output logic bit_out
);
  always_comb begin
    bit_out = 1'b0; // Reserved codes give a constant 0 [RULE18]
    if (code[4:3] == 2'b00) begin
      bit_out = coil_a[code[2:0]]; // [RULE14]
    end else if (code[4:3] == 2'b01) begin
      bit_out = coil_b[code[2:0]]; // [RULE15]
    end else begin
      case (code)
        dgs_pkg::CODE_ZERO: bit_out = 1'b0; // [RULE16]
        dgs_pkg::CODE_ONE: bit_out = 1'b1; // [RULE16]
        dgs_pkg::CODE_DIR: bit_out = dir; // [RULE17]
        dgs_pkg::CODE_STEP: bit_out = step; // [RULE16]
        default: bit_out = 1'b0;
      endcase
    end
  end
endmodule : code_select

// ===== logic/driver_datagram_sequencer.sv
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
// Function
// RULE1: Memory of 128 six-bit cells, 64 pairs
// RULE2: Select bit splits two 32-address halves
// RULE3: Select 0 registers, select 1 memory
// RULE4: Odd word upper, even word lower
// RULE5: First half holds driver configuration words
// RULE6: Word is flag plus five-bit code
// RULE7: Fetch words in order from address zero
// RULE8: Bit order follows stored code order
// RULE9: Set flag advances motor counter
// RULE10: Flag at last driver ends, counter cleared
// RULE11: Separate signal set per motor, up three
// RULE12: Second half holds shared quarter table
// RULE13: Expand table to full and shifted waves
// RULE14: Codes 0-7 select coil A bits
// RULE15: Codes 8-15 select coil B bits
// RULE16: Constant zero, one and step codes
// RULE17: Direction code gives direction bit
// RULE18: Reserved codes output constant zero
// RULE19: Snapshot signals before each datagram
// RULE20: No set flag means endless sending
// RULE21: Host memory access always possible
// RULE22: Far end of chain is motor 0
module driver_datagram_sequencer #(
  parameter int NUM_MOTORS = dgs_pkg::NUM_MOTORS,
  parameter int LINK_HALF = dgs_pkg::LINK_HALF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [6:0] addr,
  input wire logic [11:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [11:0] rdata,
  input wire logic [6:0] phase_m0,
  input wire logic [6:0] phase_m1,
  input wire logic [6:0] phase_m2,
  input wire logic [2:0] dir_in,
  input wire logic [2:0] step_in,
  input wire logic send_req,
  input wire logic sdi_s,
  output logic sck_s,
  output logic sdo_s,
  output logic cs_n_s,
  output logic busy,
  output logic [11:0] returned_bits
);
  typedef enum logic [2:0] {IDLE, SNAP, FETCH, LOW, HIGH, DONE} state_t;

  // Memory: 64 pairs, low half configuration, high half quarter table [RULE1] [RULE5] [RULE12]
  logic [5:0] mem_even [64];
  logic [5:0] mem_odd [64];
  logic [1:0] last_driver_index_reg;
  logic go_reg;
  state_t state_reg;
  logic [5:0] word_addr_reg; // Index into the 64-word configuration area
  logic [1:0] motor_reg;
  logic [7:0] snap_a_reg [3];
  logic [7:0] snap_b_reg [3];
  logic [2:0] snap_dir_reg;
  logic [2:0] snap_step_reg;
  logic [1:0] snap_slot_reg;
  logic [7:0] div_reg;
  logic [5:0] cur_word_reg;
  logic sdi_meta_reg;
  logic sdi_sync_reg;
  logic [11:0] shift_in_reg;
  logic [11:0] rdata_reg;
  logic [6:0] exp_phase;
  logic [4:0] tab_idx;
  logic [4:0] tab_idx_b;
  logic [5:0] tab_word_a;
  logic [5:0] tab_word_b;
  logic [7:0] exp_a;
  logic [7:0] exp_b;
  logic sel_bit;
  logic last_flag;
  logic is_mem;

  assign is_mem = addr[dgs_pkg::SEL_BIT]; // [RULE3]

  // Host writes into memory take effect regardless of the sequencer [RULE2] [RULE21]
  always_ff @(posedge clk) begin
    if (wr && is_mem) begin
      mem_odd[addr[5:0]] <= wdata[11:6]; // [RULE4]
      mem_even[addr[5:0]] <= wdata[5:0]; // [RULE4]
    end
  end

  // Own control register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_driver_index_reg <= dgs_pkg::LAST_RESET;
      go_reg <= 1'b0;
    end else begin
      go_reg <= 1'b0;
      if (wr && !is_mem && addr[5:0] == dgs_pkg::REG_CTRL) begin
        last_driver_index_reg <= wdata[1:0];
        go_reg <= wdata[dgs_pkg::CTRL_GO_BIT];
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads as zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 12'h000;
    end else if (rd) begin
      if (is_mem) begin
        rdata_reg <= {mem_odd[addr[5:0]], mem_even[addr[5:0]]}; // [RULE4] [RULE21]
      end else begin
        case (addr[5:0])
          dgs_pkg::REG_CTRL: rdata_reg <= {10'h000, last_driver_index_reg};
          dgs_pkg::REG_STATUS: rdata_reg <= {7'h00, state_reg != IDLE, 2'h0, motor_reg};
          dgs_pkg::REG_PHASE: rdata_reg <= shift_in_reg;
          default: rdata_reg <= 12'h000;
        endcase
      end
    end
  end
  assign rdata = rdata_reg;

  // Table read for expansion; the snapshot walks motors one per cycle
  always_comb begin
    case (snap_slot_reg)
      2'd0: exp_phase = phase_m0;
      2'd1: exp_phase = phase_m1;
      default: exp_phase = phase_m2;
    endcase
  end

  // Table entry to pair address in the upper range; a 5-bit index reaches the first 16 pairs only
  function automatic logic [5:0] table_addr(input logic [4:0] idx);
    table_addr = {2'b10, idx[4:1]};
  endfunction : table_addr

  // Both coils read the shared quarter table, each at its own index [RULE12] [RULE13]
  assign tab_word_a = tab_idx[0] ? mem_odd[table_addr(tab_idx)] : mem_even[table_addr(tab_idx)];
  assign tab_word_b = tab_idx_b[0] ? mem_odd[table_addr(tab_idx_b)] : mem_even[table_addr(tab_idx_b)];

  wave_expander u_exp (
    .phase(exp_phase),
    .table_word(tab_word_a),
    .table_word_b(tab_word_b),
    .table_index(tab_idx),
    .table_index_b(tab_idx_b),
    .coil_a_bits(exp_a),
    .coil_b_bits(exp_b)
  );

  code_select u_sel (
    .code(cur_word_reg[4:0]), // Low five bits are the code, bit 5 the flag [RULE6]
    .coil_a(snap_a_reg[motor_reg]),
    .coil_b(snap_b_reg[motor_reg]),
    .dir(snap_dir_reg[motor_reg]),
    .step(snap_step_reg[motor_reg]),
    .bit_out(sel_bit)
  );

  assign last_flag = cur_word_reg[dgs_pkg::NXM_BIT] && (motor_reg == last_driver_index_reg); // [RULE10]

  // Snapshot of per-motor sequencer signals before the datagram [RULE11] [RULE19]
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      snap_slot_reg <= 2'd0;
      snap_dir_reg <= 3'h0;
      snap_step_reg <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        snap_a_reg[i] <= 8'h00;
        snap_b_reg[i] <= 8'h00;
      end
    end else if (state_reg == SNAP) begin
      snap_a_reg[snap_slot_reg] <= exp_a;
      snap_b_reg[snap_slot_reg] <= exp_b;
      snap_slot_reg <= (snap_slot_reg == 2'd2) ? 2'd0 : 2'(snap_slot_reg + 2'd1);
      if (snap_slot_reg == 2'd0) begin
        snap_dir_reg <= dir_in;
        snap_step_reg <= step_in;
      end
    end
  end

  // Returned data from the chain passes two flops first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sdi_meta_reg <= 1'b0;
      sdi_sync_reg <= 1'b0;
    end else begin
      sdi_meta_reg <= sdi_s;
      sdi_sync_reg <= sdi_meta_reg;
    end
  end

  // Datagram engine; an all-clear flag table never ends, software must set one [RULE20]
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= IDLE;
      word_addr_reg <= 6'h00;
      motor_reg <= 2'd0;
      div_reg <= 8'h00;
      cur_word_reg <= 6'h00;
    end else begin
      case (state_reg)
        IDLE: begin
          if (send_req || go_reg) begin
            state_reg <= SNAP;
          end
        end
        SNAP: begin
          if (snap_slot_reg == 2'd2) begin
            state_reg <= FETCH;
            word_addr_reg <= 6'h00; // [RULE7]
            motor_reg <= 2'd0; // Motor 0 is the far end, its bits leave first [RULE22]
          end
        end
        FETCH: begin
          // Even word then odd word of each pair, in address order [RULE7] [RULE8]
          cur_word_reg <= word_addr_reg[0] ? mem_odd[{1'b0, word_addr_reg[5:1]}]
                                           : mem_even[{1'b0, word_addr_reg[5:1]}];
          div_reg <= 8'h00;
          state_reg <= LOW;
        end
        LOW: begin
          div_reg <= 8'(div_reg + 8'h01);
          if (div_reg == 8'(LINK_HALF - 1)) begin
            div_reg <= 8'h00;
            state_reg <= HIGH;
          end
        end
        HIGH: begin
          div_reg <= 8'(div_reg + 8'h01);
          if (div_reg == 8'(LINK_HALF - 1)) begin
            word_addr_reg <= 6'(word_addr_reg + 6'h01);
            state_reg <= FETCH;
            if (last_flag) begin
              motor_reg <= 2'd0; // [RULE10]
              state_reg <= DONE;
            end else if (cur_word_reg[dgs_pkg::NXM_BIT]) begin
              motor_reg <= 2'(motor_reg + 2'd1); // [RULE9]
            end
          end
        end
        DONE: state_reg <= IDLE;
        default: state_reg <= IDLE;
      endcase
    end
  end

  // Returned chain data is taken at the end of each low half; needs a half of four clocks or more
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_in_reg <= 12'h000;
    end else if (state_reg == LOW && div_reg == 8'(LINK_HALF - 1)) begin
      shift_in_reg <= {shift_in_reg[10:0], sdi_sync_reg};
    end
  end

  // True while a bit is on the wire, in either half
  function automatic logic bit_phase(input state_t s);
    bit_phase = (s == LOW) || (s == HIGH);
  endfunction : bit_phase

  // True from the first fetch to the last high half; fetches between bits keep the chip selected
  function automatic logic in_frame(input state_t s);
    in_frame = (s == FETCH) || bit_phase(s);
  endfunction : in_frame

  // Link clock rests low outside the high halves, so it never runs between frames
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_s <= 1'b0;
    end else begin
      sck_s <= (state_reg == HIGH);
    end
  end

  // Data held through both halves, so the chain samples a settled bit [RULE8]
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sdo_s <= 1'b0;
    end else begin
      sdo_s <= bit_phase(state_reg) ? sel_bit : 1'b0;
    end
  end

  // Chip select low for the whole frame
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs_n_s <= 1'b1;
    end else begin
      cs_n_s <= !in_frame(state_reg);
    end
  end

  // Busy lags the engine by one cycle like the other pins; the status read shows the engine itself
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_reg != IDLE);
    end
  end

  assign returned_bits = shift_in_reg;
endmodule : driver_datagram_sequencer

// ===== sim/dgs_chk.sv
`timescale 1ns/1ps
// Watches the host port and the driver link of the sequencer
module dgs_chk #(
  parameter int LINK_HALF = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [6:0] addr,
  input wire logic [11:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [11:0] rdata,
  input wire logic send_req,
  input wire logic sck_s,
  input wire logic sdo_s,
  input wire logic cs_n_s,
  input wire logic busy
);
  logic [9:0] hi_cnt_reg;
  // Counts each high phase of the link clock; a counter avoids a long repetition
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hi_cnt_reg <= 10'h000;
    end else begin
      hi_cnt_reg <= sck_s ? hi_cnt_reg + 10'h001 : 10'h000;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Memory write followed at once by a read of the same pair
  sequence wr_then_rd;
    wr && addr[6] ##1 rd && addr == $past(addr);
  endsequence
  // Idle request that should open a frame
  sequence start_seen;
    send_req && !busy;
  endsequence
  a_mem_readback: assert property (wr_then_rd |=> rdata == $past(wdata, 2)) else $error("memory readback differs");
  a_unmapped_zero: assert property (rd && !addr[6] && addr[5:0] > 6'h02 |=> rdata == 12'h000) else $error("unmapped read not zero");
  a_rdata_holds: assert property (!rd |=> $stable(rdata)) else $error("read data moved without a read");
  a_sck_framed: assert property (cs_n_s |-> !sck_s) else $error("link clock outside frame");
  a_sck_high_len: assert property ($fell(sck_s) |-> hi_cnt_reg == LINK_HALF) else $error("link clock high length");
  a_sdo_stable: assert property (sck_s && $past(sck_s) |-> $stable(sdo_s)) else $error("data moved while clock high");
  a_frame_busy: assert property (!cs_n_s |-> busy) else $error("frame open while idle");
  a_start_busy: assert property (start_seen |-> ##[1:4] busy) else $error("request not taken");
  a_start_frame: assert property ($rose(busy) |-> ##[1:8] !cs_n_s) else $error("frame did not open");
endmodule : dgs_chk

bind driver_datagram_sequencer dgs_chk #(.LINK_HALF(LINK_HALF)) u_chk (.clk(clk), .nrst(nrst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .send_req(send_req), .sck_s(sck_s), .sdo_s(sdo_s),
  .cs_n_s(cs_n_s), .busy(busy));

// ===== sim/chain_model.sv
`timescale 1ns/1ps
// Driver chain: takes each frame bit on the rising link clock
module chain_model (
  input wire logic sck_s,
  input wire logic sdo_s,
  input wire logic cs_n_s,
  output logic sdi_s
);
  logic bits [64];
  int cnt = 0;
  // A new frame restarts the capture
  always @(negedge cs_n_s) cnt = 0;
  // Bits kept in arrival order
  always @(posedge sck_s) if (!cs_n_s && cnt < 64) begin
    bits[cnt] = sdo_s;
    cnt = cnt + 1;
  end
  // Pull-up when deselected; inverted echo so a stale level never passes
  assign sdi_s = cs_n_s ? 1'b1 : ~sdo_s;
endmodule : chain_model

// ===== sim/driver_datagram_sequencer_tb.sv
`timescale 1ns/1ps
module driver_datagram_sequencer_tb;
  logic clk, nrst, wr, rd, send_req, sdi_s, sck_s, sdo_s, cs_n_s, busy;
  logic [6:0] addr;
  logic [6:0] ph [3];
  logic [11:0] wdata, rdata, ret_bits;
  logic [2:0] dir_in, step_in;
  logic [5:0] cfg [24];
  int bad_count, checks;
  // Short link half period keeps frames brief
  driver_datagram_sequencer #(.LINK_HALF(4)) DUT (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .phase_m0(ph[0]), .phase_m1(ph[1]), .phase_m2(ph[2]), .dir_in(dir_in),
    .step_in(step_in), .send_req(send_req), .sdi_s(sdi_s), .sck_s(sck_s), .sdo_s(sdo_s), .cs_n_s(cs_n_s),
    .busy(busy), .returned_bits(ret_bits));
  chain_model partner (.sck_s(sck_s), .sdo_s(sdo_s), .cs_n_s(cs_n_s), .sdi_s(sdi_s));
  task chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task give_verdict;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // Bus tasks start and end in the time step of a rising edge, so strobes may follow with no gap
  task wr_t(input logic [6:0] a, input logic [11:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_t
  task rd_chk(input logic [6:0] a, input logic [11:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", rdata, exp);
    @(posedge clk);
  endtask : rd_chk
  // Expected bit from the snapshot values; amplitude is flat since the table is
  function automatic logic exp_bit(int k);
    logic [4:0] c;
    logic [5:0] amp;
    int m;
    logic [6:0] pb;
    c = cfg[k][4:0];
    amp = 6'h2a;
    m = k < 19 ? 0 : (k < 21 ? 1 : 2);
    pb = 7'(ph[m] + 7'h20);
    if (c < 5'h06 || (c > 5'h07 && c < 5'h0e)) return amp[c[3] ? c - 5'h08 : c];
    if (c == 5'h06) return ph[m][6];
    if (c == 5'h07) return ph[m][5];
    if (c == 5'h0e) return pb[6];
    if (c == 5'h0f) return pb[5];
    if (c == 5'h11) return 1'b1;
    if (c == 5'h12) return 3'b010 >> m;
    if (c == 5'h13) return 3'b001 >> m;
    return 1'b0;
  endfunction : exp_bit
  task t_memory;
    // Table pairs up to 47 are all that a 5-bit table index can reach
    for (int i = 0; i < 48; i++) begin
      wr_t(7'h40 + 7'(i), i < 12 ? {cfg[2 * i + 1], cfg[2 * i]} : 12'haaa);
      rd_chk(7'h40 + 7'(i), i < 12 ? {cfg[2 * i + 1], cfg[2 * i]} : 12'haaa);
    end
    rd_chk(7'h05, 12'h000);
  endtask : t_memory
  task run_frame(input logic [1:0] last, input logic use_go, input int n);
    int k;
    logic [11:0] ret;
    // The control write starts the frame itself when use_go is set
    wr_t(7'h00, {9'h000, use_go, last});
    rd_chk(7'h00, {10'h000, last});
    if (!use_go) begin
      send_req <= 1'b1;
      @(posedge clk);
      send_req <= 1'b0;
    end
    k = 0;
    while (cs_n_s !== 1'b0 && k < 20) begin
      @(posedge clk);
      k++;
    end
    // Inputs move after the snapshot; the frame must not show it
    dir_in <= 3'b101;
    step_in <= 3'b110;
    rd_chk(7'h40, {cfg[1], cfg[0]});
    k = 0;
    while (busy !== 1'b0 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    chk("bit count", 12'(partner.cnt), 12'(n));
    for (k = 0; k < n; k++) chk("frame bit", {11'h000, partner.bits[k]}, {11'h000, exp_bit(k)});
    // The partner echoes each bit inverted; the last twelve come back
    ret = 12'h000;
    for (k = 0; k < n; k++) ret = {ret[10:0], ~exp_bit(k)};
    chk("returned bits", ret_bits, ret);
    rd_chk(7'h02, ret);
    rd_chk(7'h01, 12'h000);
    dir_in <= 3'b010;
    step_in <= 3'b001;
  endtask : run_frame
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #500000;
    bad_count++;
    give_verdict();
  end
  // Main sequence: reset, memory, one-driver frame, then three-driver frame
  initial begin
    {nrst, wr, rd, send_req, addr, wdata} = '0;
    ph = '{7'h40, 7'h00, 7'h20};
    dir_in = 3'b010;
    step_in = 3'b001;
    for (int k = 0; k < 19; k++) cfg[k] = k < 14 ? 6'(k) : 6'(k + 2);
    cfg[18:23] = '{6'h34, 6'h12, 6'h33, 6'h0e, 6'h2f, 6'h00};
    repeat (6) @(posedge clk);
    chk("idle", {9'h000, cs_n_s, sck_s, busy}, 12'h004);
    nrst <= 1'b1;
    t_memory();
    run_frame(2'h0, 1'b0, 19);
    run_frame(2'h2, 1'b1, 23);
    give_verdict();
  end
endmodule : driver_datagram_sequencer_tb
